//--- src/ptp_tx_stamp_pkg.sv
// Constants for the transmit timestamp capture block
package ptp_tx_stamp_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          DEPTH           = 4;
    localparam int          PTR_W           = 2;
    localparam int          CNT_W           = 3;
    localparam int          SEC_W           = 32;
    localparam int          NS_W            = 30;
    localparam int          SPID_W          = 80;
    localparam int          CRC_W           = 12;
    localparam int          KIND_W          = 4;
    localparam int          SEQ_W           = 16;
    localparam int          BANK_W          = 3;
    localparam int          DREQ_SEC_W      = 4;
    localparam int          UPPER_W         = 16;

    // Register byte offsets
    localparam logic [11:0] OFS_BANK_SELECT = 12'h100;
    localparam logic [11:0] OFS_EGRESS_SEC  = 12'h16C;
    localparam logic [11:0] OFS_EGRESS_NS   = 12'h170;
    localparam logic [11:0] OFS_MSG_HEADER  = 12'h174;
    localparam logic [11:0] OFS_DREQ_SEC    = 12'h178;
    localparam logic [11:0] OFS_DREQ_NS     = 12'h17C;
    localparam logic [11:0] OFS_UPPER_SEC   = 12'h180;
    localparam logic [11:0] OFS_CONTROL     = 12'h184;
    localparam logic [11:0] OFS_STATUS      = 12'h188;

    // Header word field positions
    localparam int          HDR_CRC_LSB     = 20;
    localparam int          HDR_KIND_LSB    = 16;
    localparam int          HDR_SEQ_LSB     = 0;

    // Control register bit positions
    localparam int          CTL_FCS_BYPASS  = 0;
    localparam int          CTL_SYNC_INSERT = 1;

    localparam logic [2:0]  PORT_BANK       = 3'h2;
    localparam logic [3:0]  KIND_DELAY_REQ  = 4'h1;
    localparam logic [11:0] CRC_POLY        = 12'h80F;
    localparam logic [11:0] CRC_INIT        = 12'h000;
    localparam logic [2:0]  COUNT_FULL      = 3'h4;
    localparam logic [2:0]  COUNT_ZERO      = 3'h0;
endpackage

//--- src/port_id_crc12.sv
// Combinational 12-bit CRC over the source port identity
`timescale 1ns/1ns
`default_nettype none
module port_id_crc12 (
    input  wire logic [ptp_tx_stamp_pkg::SPID_W-1:0] data,
    output logic      [ptp_tx_stamp_pkg::CRC_W-1:0]  crc
);
    always_comb begin
        logic [ptp_tx_stamp_pkg::CRC_W-1:0] acc;
        logic                               fb;
        acc = ptp_tx_stamp_pkg::CRC_INIT;
        fb  = 1'b0;
        // Most significant bit first
        for (int i = ptp_tx_stamp_pkg::SPID_W - 1; i >= 0; i--) begin
            fb  = acc[ptp_tx_stamp_pkg::CRC_W-1] ^ data[i];
            acc = {acc[ptp_tx_stamp_pkg::CRC_W-2:0], 1'b0};
            if (fb) begin
                acc = acc ^ ptp_tx_stamp_pkg::CRC_POLY;
            end
        end
        crc = acc;
    end
endmodule // port_id_crc12
`default_nettype wire

//--- src/ptp_tx_timestamp_capture.sv
// Transmit timestamp capture buffer with APB register access
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module ptp_tx_timestamp_capture (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_stamp_valid,
    input  wire logic        tx_frame_check_ok,
    input  wire logic [31:0] tx_stamp_seconds,
    input  wire logic [29:0] tx_stamp_nanoseconds,
    input  wire logic [79:0] tx_source_port_id,
    input  wire logic [3:0]  tx_message_kind,
    input  wire logic [15:0] tx_sequence_number,
    output logic [3:0]       delay_resp_seconds,
    output logic [29:0]      delay_resp_nanoseconds,
    output logic [15:0]      sync_upper_seconds,
    output logic             sync_insert_en,
    output logic [2:0]       tx_capture_count
);
    typedef struct packed {
        logic [ptp_tx_stamp_pkg::SEC_W-1:0]   sec;
        logic [ptp_tx_stamp_pkg::NS_W-1:0]    ns;
        logic [ptp_tx_stamp_pkg::CRC_W-1:0]   crc;
        logic [ptp_tx_stamp_pkg::KIND_W-1:0]  kind;
        logic [ptp_tx_stamp_pkg::SEQ_W-1:0]   seq;
    } entry_t;

    typedef struct packed {
        entry_t [ptp_tx_stamp_pkg::DEPTH-1:0]     fifo;
        logic [ptp_tx_stamp_pkg::PTR_W-1:0]       rd_ptr;
        logic [ptp_tx_stamp_pkg::PTR_W-1:0]       wr_ptr;
        logic [ptp_tx_stamp_pkg::CNT_W-1:0]       count;
        logic [ptp_tx_stamp_pkg::BANK_W-1:0]      bank;
        logic                                     fcs_bypass;
        logic                                     sync_insert;
        logic [ptp_tx_stamp_pkg::UPPER_W-1:0]     upper_sec;
        logic [ptp_tx_stamp_pkg::DREQ_SEC_W-1:0]  dreq_sec;
        logic [ptp_tx_stamp_pkg::NS_W-1:0]        dreq_ns;
        logic                                     ready;
        logic                                     err;
        logic [ptp_tx_stamp_pkg::DATA_W-1:0]      rdata;
    } state_t;

    logic [1:0]                           rst_sync_ff;
    logic                                 rst_n;
    state_t                               st_ff;
    state_t                               nxt_st;
    logic [ptp_tx_stamp_pkg::CRC_W-1:0]   spid_crc;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    port_id_crc12 u_crc (
        .data (tx_source_port_id),
        .crc  (spid_crc)
    );

    always_comb begin
        logic   accept;
        logic   done;
        logic   rd_setup;
        logic   in_bank;
        logic   hit;
        logic   pop;
        entry_t head;
        entry_t item;
        logic [31:0] rd;

        nxt_st   = st_ff;
        accept   = 1'b0;
        pop      = 1'b0;
        rd       = 32'h0000_0000;
        hit      = 1'b1;
        head     = st_ff.fifo[st_ff.rd_ptr];
        item     = '0;
        rd_setup = psel && penable && !st_ff.ready;
        done     = psel && penable && st_ff.ready;
        in_bank  = (st_ff.bank == ptp_tx_stamp_pkg::PORT_BANK);

        // Capture path
        accept = tx_stamp_valid && (tx_frame_check_ok || st_ff.fcs_bypass)
                 && (st_ff.count != ptp_tx_stamp_pkg::COUNT_FULL);
        item.sec  = tx_stamp_seconds;
        item.ns   = tx_stamp_nanoseconds;
        item.crc  = spid_crc;
        item.kind = tx_message_kind;
        item.seq  = tx_sequence_number;

        // Register decode, answer one cycle into the access phase
        case (paddr)
            ptp_tx_stamp_pkg::OFS_BANK_SELECT: begin
                rd[ptp_tx_stamp_pkg::BANK_W-1:0] = st_ff.bank;
            end
            ptp_tx_stamp_pkg::OFS_EGRESS_SEC: begin
                hit = in_bank;
                rd  = head.sec;
            end
            ptp_tx_stamp_pkg::OFS_EGRESS_NS: begin
                hit = in_bank;
                rd[ptp_tx_stamp_pkg::NS_W-1:0] = head.ns;
            end
            ptp_tx_stamp_pkg::OFS_MSG_HEADER: begin
                hit = in_bank;
                rd[ptp_tx_stamp_pkg::HDR_CRC_LSB +: ptp_tx_stamp_pkg::CRC_W]   = head.crc;
                rd[ptp_tx_stamp_pkg::HDR_KIND_LSB +: ptp_tx_stamp_pkg::KIND_W] = head.kind;
                rd[ptp_tx_stamp_pkg::HDR_SEQ_LSB +: ptp_tx_stamp_pkg::SEQ_W]   = head.seq;
            end
            ptp_tx_stamp_pkg::OFS_DREQ_SEC: begin
                hit = in_bank;
                rd[ptp_tx_stamp_pkg::DREQ_SEC_W-1:0] = st_ff.dreq_sec;
            end
            ptp_tx_stamp_pkg::OFS_DREQ_NS: begin
                hit = in_bank;
                rd[ptp_tx_stamp_pkg::NS_W-1:0] = st_ff.dreq_ns;
            end
            ptp_tx_stamp_pkg::OFS_UPPER_SEC: begin
                hit = in_bank;
                rd[ptp_tx_stamp_pkg::UPPER_W-1:0] = st_ff.upper_sec;
            end
            ptp_tx_stamp_pkg::OFS_CONTROL: begin
                rd[ptp_tx_stamp_pkg::CTL_FCS_BYPASS]  = st_ff.fcs_bypass;
                rd[ptp_tx_stamp_pkg::CTL_SYNC_INSERT] = st_ff.sync_insert;
            end
            ptp_tx_stamp_pkg::OFS_STATUS: begin
                rd[ptp_tx_stamp_pkg::CNT_W-1:0] = st_ff.count;
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        if (rd_setup) begin
            nxt_st.ready = 1'b1;
            nxt_st.err   = !hit;
            nxt_st.rdata = (hit && !pwrite) ? rd : 32'h0000_0000;
        end else begin
            nxt_st.ready = 1'b0;
            nxt_st.err   = 1'b0;
            nxt_st.rdata = 32'h0000_0000;
        end

        // Effects at the completing edge
        if (done && hit) begin
            if (pwrite) begin
                if (paddr == ptp_tx_stamp_pkg::OFS_BANK_SELECT && pstrb[0]) begin
                    nxt_st.bank = pwdata[ptp_tx_stamp_pkg::BANK_W-1:0];
                end
                if (paddr == ptp_tx_stamp_pkg::OFS_UPPER_SEC) begin
                    if (pstrb[0]) begin
                        nxt_st.upper_sec[7:0] = pwdata[7:0];
                    end
                    if (pstrb[1]) begin
                        nxt_st.upper_sec[15:8] = pwdata[15:8];
                    end
                end
                if (paddr == ptp_tx_stamp_pkg::OFS_CONTROL && pstrb[0]) begin
                    nxt_st.fcs_bypass  = pwdata[ptp_tx_stamp_pkg::CTL_FCS_BYPASS];
                    nxt_st.sync_insert = pwdata[ptp_tx_stamp_pkg::CTL_SYNC_INSERT];
                end
            end else if (paddr == ptp_tx_stamp_pkg::OFS_MSG_HEADER
                         && st_ff.count != ptp_tx_stamp_pkg::COUNT_ZERO) begin
                pop = 1'b1;
            end
        end

        if (accept) begin
            nxt_st.fifo[st_ff.wr_ptr] = item;
            nxt_st.wr_ptr = st_ff.wr_ptr + 2'h1;
            if (tx_message_kind == ptp_tx_stamp_pkg::KIND_DELAY_REQ) begin
                nxt_st.dreq_sec = tx_stamp_seconds[ptp_tx_stamp_pkg::DREQ_SEC_W-1:0];
                nxt_st.dreq_ns  = tx_stamp_nanoseconds;
            end
        end
        if (pop) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + 2'h1;
        end
        if (accept && !pop) begin
            nxt_st.count = st_ff.count + 3'h1;
        end else if (pop && !accept) begin
            nxt_st.count = st_ff.count - 3'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata                 = st_ff.rdata;
    assign pready                 = st_ff.ready;
    assign pslverr                = st_ff.err;
    assign delay_resp_seconds     = st_ff.dreq_sec;
    assign delay_resp_nanoseconds = st_ff.dreq_ns;
    assign sync_upper_seconds     = st_ff.upper_sec;
    assign sync_insert_en         = st_ff.sync_insert;
    assign tx_capture_count       = st_ff.count;
endmodule // ptp_tx_timestamp_capture
`default_nettype wire

//--- test/ptp_tx_stamp_properties.sv
// Checker for the transmit timestamp capture block
`timescale 1ns/1ns
`default_nettype none
module ptp_tx_stamp_props (
    input wire logic        ref_clk, nrst, psel, penable, pready, pslverr,
    input wire logic        tx_stamp_valid, tx_frame_check_ok,
    input wire logic [3:0]  tx_message_kind, delay_resp_seconds,
    input wire logic [31:0] tx_stamp_seconds,
    input wire logic [29:0] tx_stamp_nanoseconds, delay_resp_nanoseconds,
    input wire logic [15:0] sync_upper_seconds,
    input wire logic [2:0]  tx_capture_count
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire take = tx_stamp_valid && tx_frame_check_ok && tx_capture_count < 3'h4 && !pready;
    apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("no ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    count_push_a: assert property (take |=>
        tx_capture_count == $past(tx_capture_count) + 3'h1) else $error("count not raised");
    count_cap_a: assert property (tx_capture_count <= 3'h4) else $error("count high");
    count_hold_a: assert property (!tx_stamp_valid && !pready |=>
        $stable(tx_capture_count)) else $error("count moved");
    dreq_take_a: assert property (take && tx_message_kind == 4'h1 |=>
        delay_resp_nanoseconds == $past(tx_stamp_nanoseconds)
        && delay_resp_seconds == $past(tx_stamp_seconds[3:0])) else $error("bad dreq");
    dreq_cause_a: assert property ($changed(delay_resp_nanoseconds) |->
        $past(tx_stamp_valid)) else $error("dreq moved");
    upper_hold_a: assert property ($changed(sync_upper_seconds) |->
        $past(pready) || $past(pready, 2)) else $error("upper moved");
endmodule // ptp_tx_stamp_props
bind ptp_tx_timestamp_capture ptp_tx_stamp_props i_ptp_tx_stamp_props (.ref_clk, .nrst,
    .psel, .penable, .pready, .pslverr, .tx_stamp_valid, .tx_frame_check_ok,
    .tx_message_kind, .delay_resp_seconds, .tx_stamp_seconds, .tx_stamp_nanoseconds,
    .delay_resp_nanoseconds, .sync_upper_seconds, .tx_capture_count);
`default_nettype wire

//--- test/apb_host_model.sv
// Host model driving the APB register port
`timescale 1ns/1ns
`default_nettype none
module apb_host_model (
    input  wire logic        ref_clk, pready, pslverr,
    input  wire logic [31:0] prdata,
    output var  logic        psel, penable, pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // Hold the request until pready is sampled high at a rising edge
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        // Answer taken at that same edge; a missing answer shows as an unknown error flag
        r = prdata;
        e = (pready === 1'b1) ? pslverr : 1'bx;
        {psel, penable} <= 2'b00;
    endtask
endmodule // apb_host_model
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the transmit timestamp capture block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        ref_clk = '0, nrst = '0, tx_stamp_valid = '0, tx_frame_check_ok = '0, byp = '0;
    logic        psel, penable, pwrite, pready, pslverr, sync_insert_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, tx_stamp_seconds = '0, rs, q_sec[$], q_ns[$], q_hdr[$];
    logic [3:0]  tx_message_kind = '0, delay_resp_seconds, m_ds = '0;
    logic [29:0] tx_stamp_nanoseconds = '0, delay_resp_nanoseconds, m_dn = '0;
    logic [79:0] tx_source_port_id = '0;
    logic [15:0] tx_sequence_number = '0, sync_upper_seconds;
    logic [2:0]  tx_capture_count;
    int          err_total = 0, n_checks = 0;
    always #25 ref_clk = ~ref_clk;
    ptp_tx_timestamp_capture i_ptp_tx_timestamp_capture (.ref_clk, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .tx_stamp_valid,
        .tx_frame_check_ok, .tx_stamp_seconds, .tx_stamp_nanoseconds, .tx_source_port_id,
        .tx_message_kind, .tx_sequence_number, .delay_resp_seconds, .delay_resp_nanoseconds,
        .sync_upper_seconds, .sync_insert_en, .tx_capture_count);
    apb_host_model i_apb_host_model (.ref_clk, .pready, .pslverr, .prdata, .psel, .penable,
        .pwrite, .paddr, .pwdata);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic xe, input logic [31:0] xd);
        logic [31:0] r;
        logic        e;
        i_apb_host_model.xfer(w, a, d, r, e);
        chk("pslverr", {31'h0, e}, {31'h0, xe});
        if (!w) chk("prdata", r, xd);
    endtask
    task automatic push(input logic ok, input logic [3:0] k);
        logic [31:0] s = $urandom;
        logic [29:0] n = 30'($urandom);
        logic [15:0] q = 16'($urandom);
        logic [79:0] p = {$urandom, $urandom, 16'($urandom)};
        logic [11:0] c = 12'h000;
        for (int i = 79; i >= 0; i--)
            c = {c[10:0], 1'b0} ^ ((c[11] ^ p[i]) ? 12'h80F : 12'h000);
        if ((ok || byp) && q_sec.size() < 4) begin
            q_sec.push_back(s);
            q_ns.push_back({2'h0, n});
            q_hdr.push_back({c, k, q});
            if (k == 4'h1) {m_ds, m_dn} = {s[3:0], n};
        end
        @(posedge ref_clk);
        {tx_stamp_valid, tx_frame_check_ok, tx_stamp_seconds} <= {1'b1, ok, s};
        {tx_stamp_nanoseconds, tx_source_port_id, tx_message_kind, tx_sequence_number} <= {n, p, k, q};
        @(posedge ref_clk);
        tx_stamp_valid <= 1'b0;
        #1 chk("count", {29'h0, tx_capture_count}, 32'(q_sec.size()));
    endtask
    task automatic drain;
        while (q_sec.size() > 0) begin
            acc(0, 12'h188, '0, 0, 32'(q_sec.size()));
            acc(0, 12'h16C, '0, 0, q_sec.pop_front());
            acc(0, 12'h170, '0, 0, q_ns.pop_front());
            acc(0, 12'h174, '0, 0, q_hdr.pop_front());
            #1 chk("count", {29'h0, tx_capture_count}, 32'(q_sec.size()));
        end
    endtask
    task automatic tally_and_finish(input int extra);
        err_total += extra;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial #1000000 tally_and_finish(1);
    initial begin
        rs = $urandom(43);
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        acc(0, 12'h16C, '0, 1, '0);
        acc(1, 12'h100, 32'h2, 0, '0);
        for (int a = 'h16C; a <= 'h180; a += 4) acc(0, 12'(a), '0, 0, '0);
        acc(0, 12'h1F0, '0, 1, '0);
        $display("reset values test done");
        rs = $urandom;
        acc(1, 12'h180, rs, 0, '0);
        acc(1, 12'h184, 32'h2, 0, '0);
        acc(0, 12'h180, '0, 0, {16'h0, rs[15:0]});
        chk("upper", {16'h0, sync_upper_seconds}, {16'h0, rs[15:0]});
        chk("insert", {31'h0, sync_insert_en}, 32'h1);
        $display("upper seconds test done");
        for (int i = 0; i < 6; i++) push(i != 3, i[0] ? 4'h1 : 4'($urandom));
        acc(1, 12'h16C, rs, 0, '0);
        drain();
        chk("dreq_sec", {28'h0, delay_resp_seconds}, {28'h0, m_ds});
        chk("dreq_ns", {2'h0, delay_resp_nanoseconds}, {2'h0, m_dn});
        acc(0, 12'h17C, '0, 0, {2'h0, m_dn});
        $display("capture test done");
        byp = 1'b1;
        acc(1, 12'h184, 32'h3, 0, '0);
        push(1'b0, 4'h1);
        drain();
        acc(0, 12'h178, '0, 0, {28'h0, m_ds});
        $display("bypass test done");
        tally_and_finish(0);
    end
endmodule // testbench
`default_nettype wire
